// *** rtl/fh_hdr_pkg.sv ***
// shared constants for the flow identifier and message identifier header logic
package fh_hdr_pkg;
  localparam int FLOW_W = 16;
  localparam int SEQ_W = 8;
  localparam int SUB_W = 7;
  localparam int MSGID_W = 16;
  localparam int LAST_BIT = 15;
  localparam int SUB_LSB = 8;
  localparam int SEQ_LSB = 0;
  localparam logic [7:0] MSGTYPE_IQ = 8'h00;
  localparam logic [7:0] MSGTYPE_CTRL = 8'h02;
  // counter selection: {plane, direction}
  localparam logic [1:0] CNT_UP_DL = 2'h0;
  localparam logic [1:0] CNT_UP_UL = 2'h1;
  localparam logic [1:0] CNT_CP_DL = 2'h2;
  localparam logic [1:0] CNT_CP_UL = 2'h3;
  localparam int NUM_CNT = 4;
  // apb register offsets
  localparam logic [7:0] REG_WIDTHS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [7:0] REG_LAST_FLOW = 8'h10;
  localparam logic [7:0] REG_ERR_COUNT = 8'h14;
  localparam logic [31:0] WIDTHS_RST = 32'h00004444;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] MASK_RST = 32'h00000000;
  // status bits
  localparam int ST_GAP = 0;
  localparam int ST_DUP = 1;
  localparam int ST_FRAG = 2;
  localparam int ST_WIDTH = 3;
  localparam int ST_W = 4;
endpackage

// *** rtl/fh_link_if.sv ***
// header link between the transmitting node and the receiving checker
`timescale 1ns/1ps
`default_nettype none
interface fh_link_if;
  logic valid;
  logic ready;
  logic [7:0] msg_type;
  logic dir_ul;
  logic [15:0] flow_identifier;
  logic [15:0] message_identifier;
  modport tx (output valid, output msg_type, output dir_ul, output flow_identifier,
    output message_identifier, input ready);
  modport rx (input valid, input msg_type, input dir_ul, input flow_identifier,
    input message_identifier, output ready);
endinterface
`default_nettype wire

// *** rtl/flow_id_pack.sv ***
// packs the four configurable flow identifier sub-fields, or extracts the unit port from one
`timescale 1ns/1ps
`default_nettype none
module flow_id_pack
  import fh_hdr_pkg::*;
(
  input wire logic [3:0] w_pu,
  input wire logic [3:0] w_bs,
  input wire logic [3:0] w_cc,
  input wire logic [3:0] w_sp,
  input wire logic [15:0] processing_unit_port,
  input wire logic [15:0] band_sector_field,
  input wire logic [15:0] component_carrier_field,
  input wire logic [15:0] spatial_stream_port,
  input wire logic [15:0] flow_in,
  output logic [15:0] flow_out,
  output logic [15:0] pu_out,
  output logic width_bad
);
  logic [4:0] lo_bs, lo_cc, lo_pu, total;
  always_comb begin
    // fields stacked from spatial stream upward, padding sits under the unit port
    lo_cc = {1'b0, w_sp};
    lo_bs = lo_cc + {1'b0, w_cc};
    lo_pu = lo_bs + {1'b0, w_bs};
    total = lo_pu + {1'b0, w_pu};
    width_bad = (total > 5'd16);
    flow_out = (spatial_stream_port & ((16'h0001 << w_sp) - 16'h0001))
      | ((component_carrier_field & ((16'h0001 << w_cc) - 16'h0001)) << lo_cc)
      | ((band_sector_field & ((16'h0001 << w_bs) - 16'h0001)) << lo_bs)
      | ((processing_unit_port & ((16'h0001 << w_pu) - 16'h0001)) << (5'd16 - {1'b0, w_pu}));
    pu_out = (flow_in >> (5'd16 - {1'b0, w_pu})) & ((16'h0001 << w_pu) - 16'h0001);
  end
endmodule
`default_nettype wire

// *** rtl/fh_hdr_tx.sv ***
// transmitting end: builds flow identifier and message identifier per message
`timescale 1ns/1ps
`default_nettype none
module fh_hdr_tx
  import fh_hdr_pkg::*;
#(
  parameter int FLOWS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  fh_link_if.tx link,
  input wire logic [3:0] w_pu,
  input wire logic [3:0] w_bs,
  input wire logic [3:0] w_cc,
  input wire logic [3:0] w_sp,
  input wire logic app_frag,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_ctrl,
  input wire logic req_ul,
  input wire logic req_last,
  input wire logic [$clog2(FLOWS)-1:0] req_slot,
  input wire logic [15:0] processing_unit_port,
  input wire logic [15:0] band_sector_field,
  input wire logic [15:0] component_carrier_field,
  input wire logic [15:0] spatial_stream_port
);
  typedef struct packed {
    logic [FLOWS*NUM_CNT-1:0][SEQ_W-1:0] seq;
    logic [FLOWS-1:0][SUB_W-1:0] sub;
    logic valid;
    logic [7:0] mtype;
    logic ul;
    logic [15:0] flow;
    logic [15:0] msgid;
  } tx_state_t;
  tx_state_t s_r, s_nxt;
  logic [15:0] flow_w;
  logic [1:0] csel;
  int idx;
  flow_id_pack u_pack (
    .w_pu(w_pu), .w_bs(w_bs), .w_cc(w_cc), .w_sp(w_sp),
    .processing_unit_port(processing_unit_port), .band_sector_field(band_sector_field),
    .component_carrier_field(component_carrier_field),
    .spatial_stream_port(spatial_stream_port),
    .flow_in(16'h0000), .flow_out(flow_w), .pu_out(), .width_bad()
  );
  always_comb begin
    s_nxt = s_r;
    csel = {req_ctrl, req_ul};
    idx = int'(req_slot) * NUM_CNT + int'(csel);
    if (s_r.valid && link.ready) begin
      s_nxt.valid = 1'b0;
    end
    if (req_valid && (!s_r.valid || link.ready)) begin
      s_nxt.valid = 1'b1;
      s_nxt.mtype = req_ctrl ? MSGTYPE_CTRL : MSGTYPE_IQ;
      s_nxt.ul = req_ul;
      s_nxt.flow = flow_w;
      s_nxt.msgid[SEQ_LSB +: SEQ_W] = s_r.seq[idx];
      if (req_ctrl || app_frag) begin
        s_nxt.msgid[SUB_LSB +: SUB_W] = '0;
        s_nxt.msgid[LAST_BIT] = 1'b1;
        s_nxt.seq[idx] = s_r.seq[idx] + 8'h01;
      end else begin
        s_nxt.msgid[SUB_LSB +: SUB_W] = s_r.sub[req_slot];
        s_nxt.msgid[LAST_BIT] = req_last;
        s_nxt.sub[req_slot] = req_last ? '0 : s_r.sub[req_slot] + 7'h01;
        if (req_last) begin
          s_nxt.seq[idx] = s_r.seq[idx] + 8'h01;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign req_ready = !s_r.valid || link.ready;
  assign link.valid = s_r.valid;
  assign link.msg_type = s_r.mtype;
  assign link.dir_ul = s_r.ul;
  assign link.flow_identifier = s_r.flow;
  assign link.message_identifier = s_r.msgid;
endmodule
`default_nettype wire

// *** rtl/fh_hdr_rx.sv ***
// receiving end: checks sequence and fragment fields, apb registers and interrupt
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module fh_hdr_rx
  import fh_hdr_pkg::*;
#(
  parameter int FLOWS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  fh_link_if.rx link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [3:0] w_pu,
  output logic [3:0] w_bs,
  output logic [3:0] w_cc,
  output logic [3:0] w_sp,
  output logic app_frag,
  output logic msg_valid,
  output logic [$clog2(FLOWS)-1:0] msg_slot,
  output logic [SEQ_W-1:0] msg_seq,
  output logic [15:0] ul_processing_unit_port
);
  typedef struct packed {
    logic [FLOWS*NUM_CNT-1:0][SEQ_W-1:0] exp;
    logic [FLOWS*NUM_CNT-1:0] seen;
    logic [FLOWS-1:0][SUB_W-1:0] sub;
    logic [31:0] widths;
    logic [31:0] ctrl;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [15:0] last_flow;
    logic [15:0] err_cnt;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
    logic mvalid;
    logic [$clog2(FLOWS)-1:0] mslot;
    logic [SEQ_W-1:0] mseq;
    logic [15:0] pu;
  } rx_state_t;
  rx_state_t s_r, s_nxt;
  logic [15:0] pu_w;
  logic width_bad_w;
  logic [$clog2(FLOWS)-1:0] slot;
  logic [1:0] csel;
  logic [SEQ_W-1:0] seq_in;
  logic [SUB_W-1:0] sub_in;
  logic last_in;
  logic is_ctrl;
  logic typed;
  logic access;
  logic done;
  logic [ST_W-1:0] ev;
  int idx;
  flow_id_pack u_pack (
    .w_pu(s_r.widths[15:12]), .w_bs(s_r.widths[11:8]), .w_cc(s_r.widths[7:4]),
    .w_sp(s_r.widths[3:0]), .processing_unit_port(16'h0000), .band_sector_field(16'h0000),
    .component_carrier_field(16'h0000), .spatial_stream_port(16'h0000),
    .flow_in(link.flow_identifier), .flow_out(), .pu_out(pu_w), .width_bad(width_bad_w)
  );
  assign link.ready = 1'b1;
  always_comb begin
    s_nxt = s_r;
    ev = '0;
    s_nxt.mvalid = 1'b0;
    slot = link.flow_identifier[$clog2(FLOWS)-1:0];
    is_ctrl = (link.msg_type == MSGTYPE_CTRL);
    typed = is_ctrl || (link.msg_type == MSGTYPE_IQ);
    csel = {is_ctrl, link.dir_ul};
    idx = int'(slot) * NUM_CNT + int'(csel);
    seq_in = link.message_identifier[SEQ_LSB +: SEQ_W];
    sub_in = link.message_identifier[SUB_LSB +: SUB_W];
    last_in = link.message_identifier[LAST_BIT];
    if (link.valid && typed) begin
      s_nxt.last_flow = link.flow_identifier;
      s_nxt.pu = pu_w;
      if (is_ctrl || s_r.ctrl[0]) begin
        if (sub_in != '0 || !last_in) begin
          ev[ST_FRAG] = 1'b1;
        end
      end else if (sub_in != s_r.sub[slot]) begin
        ev[ST_FRAG] = 1'b1;
      end
      if (!is_ctrl && !s_r.ctrl[0]) begin
        s_nxt.sub[slot] = last_in ? '0 : sub_in + 7'h01;
      end
      if (is_ctrl || s_r.ctrl[0] || last_in) begin
        if (s_r.seen[idx] && seq_in != s_r.exp[idx]) begin
          if ((seq_in - s_r.exp[idx]) < 8'h80) begin
            ev[ST_GAP] = 1'b1;
          end else begin
            ev[ST_DUP] = 1'b1;
          end
        end
        s_nxt.exp[idx] = seq_in + 8'h01;
        s_nxt.seen[idx] = 1'b1;
        s_nxt.mvalid = 1'b1;
        s_nxt.mslot = slot;
        s_nxt.mseq = seq_in;
      end
    end
    ev[ST_WIDTH] = width_bad_w;
    if (ev != '0) begin
      s_nxt.err_cnt = s_r.err_cnt + 16'h0001;
    end
    // apb slave, one wait state; writes land on the completing edge
    access = psel && penable && !s_r.ready;
    done = psel && penable && s_r.ready;
    s_nxt.ready = access;
    s_nxt.slverr = 1'b0;
    if (access) begin
      s_nxt.rdata = 32'h00000000;
      case (paddr)
        REG_WIDTHS: s_nxt.rdata = s_r.widths;
        REG_CTRL: s_nxt.rdata = s_r.ctrl;
        REG_STATUS: begin
          s_nxt.rdata = {{(32-ST_W){1'b0}}, s_r.status};
          if (!pwrite) begin
            s_nxt.status = '0;
          end
        end
        REG_MASK: s_nxt.rdata = {{(32-ST_W){1'b0}}, s_r.mask};
        REG_LAST_FLOW: s_nxt.rdata = {16'h0000, s_r.last_flow};
        REG_ERR_COUNT: s_nxt.rdata = {16'h0000, s_r.err_cnt};
        default: s_nxt.slverr = 1'b1;
      endcase
    end
    if (done && pwrite) begin
      case (paddr)
        REG_WIDTHS: s_nxt.widths = {16'h0000, pwdata[15:0]};
        REG_CTRL: s_nxt.ctrl = {31'h00000000, pwdata[0]};
        REG_MASK: s_nxt.mask = pwdata[ST_W-1:0];
        REG_ERR_COUNT: s_nxt.err_cnt = 16'h0000;
        default: s_nxt.err_cnt = s_nxt.err_cnt;
      endcase
    end
    s_nxt.status = s_nxt.status | ev; // set wins over read clear
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.widths <= WIDTHS_RST;
      s_r.ctrl <= CTRL_RST;
      s_r.mask <= MASK_RST[ST_W-1:0];
    end else begin
      s_r <= s_nxt;
    end
  end
  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.slverr;
  assign irq = s_r.irq;
  assign w_pu = s_r.widths[15:12];
  assign w_bs = s_r.widths[11:8];
  assign w_cc = s_r.widths[7:4];
  assign w_sp = s_r.widths[3:0];
  assign app_frag = s_r.ctrl[0];
  assign msg_valid = s_r.mvalid;
  assign msg_slot = s_r.mslot;
  assign msg_seq = s_r.mseq;
  assign ul_processing_unit_port = s_r.pu;
endmodule
`default_nettype wire

// *** tb/fh_link_asserts.sv ***
// interface-side assertions for the header link
`timescale 1ns/1ps
`default_nettype none
module fh_link_asserts
  import fh_hdr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic valid,
  input wire logic ready,
  input wire logic [7:0] msg_type,
  input wire logic dir_ul,
  input wire logic [15:0] flow_identifier,
  input wire logic [15:0] message_identifier
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic iq, last, open, cp;
  assign iq = valid && msg_type == MSGTYPE_IQ;
  assign cp = valid && msg_type == MSGTYPE_CTRL;
  assign last = message_identifier[LAST_BIT];
  assign open = iq && !last;
  a_type_legal: assert property (valid |-> iq || cp)
    else $error("unexpected message type");
  a_ctrl_last: assert property (cp |-> last)
    else $error("control message without last flag");
  a_ctrl_sub: assert property (cp |-> message_identifier[14:8] == 7'h00)
    else $error("control message with nonzero subsequence");
  a_frag_iq_only: assert property (valid && !last |-> iq)
    else $error("open fragment on non iq message");
  a_sub_step: assert property (open |=> iq && message_identifier[14:8] ==
    $past(message_identifier[14:8]) + 7'h01) else $error("subsequence did not step");
  a_seq_hold: assert property (open |=> $stable(message_identifier[7:0]))
    else $error("sequence changed inside fragments");
  a_first_sub: assert property (iq && !$past(open) |-> message_identifier[14:8] == 7'h00)
    else $error("first fragment subsequence not zero");
  a_seq_step: assert property (valid && last ##1 valid && $stable(flow_identifier) &&
    $stable(msg_type) && $stable(dir_ul) |-> message_identifier[7:0] ==
    $past(message_identifier[7:0]) + 8'h01) else $error("sequence did not advance");
  c_frag_chain: cover property (open ##1 iq && last);
  c_ctrl_ul: cover property (cp && dir_ul);
  c_wrap: cover property (valid && message_identifier[7:0] == 8'hff ##1 valid &&
    message_identifier[7:0] == 8'h00);
endmodule
`default_nettype wire

// *** tb/tb_fronthaul_flow_id_seq_header.sv ***
// self-checking bench joining both header ends over the link
`timescale 1ns/1ps
`default_nettype none
module tb_fronthaul_flow_id_seq_header
  import fh_hdr_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, app_frag, serr;
  logic req_valid, req_ready, req_ctrl, req_ul, req_last, msg_valid, app_m, c, u1;
  logic [3:0] w_pu, w_bs, w_cc, w_sp;
  logic [1:0] req_slot, msg_slot;
  logic [7:0] paddr, msg_seq;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pu, bs, cc, sp, s, ul_port, wm;
  logic [15:0] cfgs [2] = '{16'h6334, 16'h3334};
  logic [7:0] seq_m [4][4];
  logic [6:0] sub_m;
  int err_total, num_checks, seed, nf, nmsg, nseen;
  fh_link_if link ();
  fh_hdr_tx fh_hdr_tx_inst (.pclk(pclk), .presetn(presetn), .link(link), .w_pu(w_pu),
    .w_bs(w_bs), .w_cc(w_cc), .w_sp(w_sp), .app_frag(app_frag), .req_valid(req_valid),
    .req_ready(req_ready), .req_ctrl(req_ctrl), .req_ul(req_ul), .req_last(req_last),
    .req_slot(req_slot), .processing_unit_port(pu), .band_sector_field(bs),
    .component_carrier_field(cc), .spatial_stream_port(sp));
  fh_hdr_rx fh_hdr_rx_inst (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .w_pu(w_pu), .w_bs(w_bs), .w_cc(w_cc),
    .w_sp(w_sp), .app_frag(app_frag), .msg_valid(msg_valid), .msg_slot(msg_slot),
    .msg_seq(msg_seq), .ul_processing_unit_port(ul_port));
  fh_link_asserts fh_link_asserts_inst (.pclk(pclk), .presetn(presetn), .valid(link.valid),
    .ready(link.ready), .msg_type(link.msg_type), .dir_ul(link.dir_ul),
    .flow_identifier(link.flow_identifier), .message_identifier(link.message_identifier));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (msg_valid === 1'b1) begin
      nseen++;
    end
  end
  function automatic logic [15:0] rnd(logic [3:0] w);
    rnd = 16'($random(seed)) & ((16'h1 << w) - 16'h1);
  endfunction
  function automatic logic [15:0] pack(logic [15:0] w);
    pack = (pu << (16 - w[15:12])) | (bs << (32'(w[7:4]) + w[3:0])) | (cc << w[3:0]) | sp;
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_hi(ref logic f);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (f !== 1'b1 && n < 50);
    if (f !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_hi(pready);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(logic cv, logic u, logic l, logic [1:0] sl);
    logic [15:0] e;
    req_valid <= 1'b1;
    req_ctrl <= cv;
    req_ul <= u;
    req_last <= l;
    req_slot <= sl;
    wait_hi(req_ready);
    #1;
    e = {l, sub_m, seq_m[sl][{cv, u}]};
    if (cv || app_m) e = {8'h80, seq_m[sl][{cv, u}]};
    chk("flow_identifier", {16'h0, pack(wm)}, {16'h0, link.flow_identifier});
    chk("message_identifier", {16'h0, e}, {16'h0, link.message_identifier});
    chk("msg_type", {24'h0, cv ? MSGTYPE_CTRL : MSGTYPE_IQ}, {24'h0, link.msg_type});
    if (cv || app_m || l) begin
      nmsg++;
      seq_m[sl][{cv, u}]++;
      sub_m = 7'h00;
    end else begin
      sub_m++;
    end
  endtask
  task automatic idle_then_send(logic [1:0] sl);
    req_valid <= 1'b0;
    @(posedge pclk);
    send(1'b0, 1'b0, 1'b1, sl);
    req_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    seed = 32'h975bac36;
    presetn = 1'b0;
    {psel, penable, pwrite, req_valid, req_ctrl, req_ul, req_last, app_m, serr} = '0;
    {paddr, pwdata, pu, bs, cc, sp, s, req_slot, sub_m, rd} = '0;
    seq_m = '{default: 8'h00};
    wm = 16'h4444;
    err_total = 0;
    num_checks = 0;
    nmsg = 0;
    nseen = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_WIDTHS, 32'h0);
    chk("widths reset", WIDTHS_RST, rd);
    apb(1'b0, REG_MASK, 32'h0);
    chk("mask reset", MASK_RST, rd);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped slverr", 32'h1, {31'h0, serr});
    apb(1'b1, REG_MASK, 32'h0000000f);
    send(1'b0, 1'b0, 1'b1, 2'd0);
    send(1'b0, 1'b0, 1'b1, 2'd0);
    idle_then_send(2'd1);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status duplicate", 32'h1 << ST_DUP, rd);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status cleared", 32'h0, rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, REG_MASK, 32'h00000000);
    idle_then_send(2'd2);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status masked", 32'h1 << ST_DUP, rd);
    apb(1'b1, REG_CTRL, 32'h1);
    app_m = 1'b1;
    for (int i = 0; i < 3; i++) send(1'b0, 1'b1, i == 2, 2'd3);
    req_valid <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h0);
    app_m = 1'b0;
    foreach (cfgs[k]) begin
      apb(1'b1, REG_WIDTHS, {16'h0, cfgs[k]});
      wm = cfgs[k];
      apb(1'b0, REG_WIDTHS, 32'h0);
      chk("widths", {16'h0, wm}, rd);
      repeat (30) begin
        s = rnd(wm[3:0]);
        pu <= rnd(wm[15:12]);
        bs <= rnd(wm[11:8]);
        cc <= rnd(wm[7:4]);
        sp <= s;
        c = 1'($random(seed));
        nf = 1 + ($random(seed) & 3);
        u1 = 1'($random(seed));
        for (int i = 0; i < nf; i++) send(c, u1, i == nf - 1, s[1:0]);
      end
      req_valid <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("unit port", {16'h0, pu}, {16'h0, ul_port});
    end
    repeat (258) send(1'b1, 1'b1, 1'b0, s[1:0]);
    req_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("msg_seq", {24'h0, seq_m[s[1:0]][3] - 8'h01}, {24'h0, msg_seq});
    chk("msg_slot", {30'h0, s[1:0]}, {30'h0, msg_slot});
    chk("msg_valid count", nmsg, nseen);
    print_verdict();
  end
endmodule
`default_nettype wire
